// file: rtl/attr_pal_cfg.svh
// Offsets, indices, reset values and codes of the attribute and palette register block.
`ifndef ATTR_PAL_CFG_SVH
`define ATTR_PAL_CFG_SVH

`define IO_ATTR_WRITE 16'h03c0
`define IO_ATTR_READ 16'h03c1
`define IO_PIXEL_MASK 16'h03c6
`define IO_READ_INDEX 16'h03c7
`define IO_WRITE_INDEX 16'h03c8
`define IO_PALETTE_DATA 16'h03c9

`define IDX_BORDER 5'h11
`define IDX_PLANE 5'h12
`define IDX_PAN 5'h13
`define IDX_COLOUR_SEL 5'h14

`define ATTR_RESET 8'h00
`define MASK_RESET 8'hff
`define INDEX_RESET 8'h00
`define READ_ZERO 8'h00

`define CTRL_IDLE 2'b00
`define CTRL_INDEX 2'b11
`define CTRL_DATA 2'b01
`define STATUS_WRITE 2'b00
`define STATUS_READ 2'b11

`define BYTE_FIRST 2'h0
`define BYTE_SECOND 2'h1
`define BYTE_LAST 2'h2
`define INDEX_STEP 8'h01

`define PAN_LINEAR_MAX 4'h7
`define PAN_NINE_ZERO 4'h8
`define PAN_STEP 4'h1
`define PAN_NONE 4'h0

`define MUX_PAIR_20 2'b00
`define MUX_PAIR_54 2'b01
`define MUX_PAIR_31 2'b10
`define MUX_PAIR_7 2'b11

`endif

// file: rtl/attr_pal_pkg.sv
// Types shared by the attribute and palette register block.
package attr_pal_pkg;

    typedef struct packed {
        logic [15:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
        logic [4:0] attr_index;
    } io_req_t;

    typedef struct packed {
        logic lock;
        logic palette_source_enable;
        logic mode256;
        logic vid_select;
        logic nine_dot;
        logic text;
    } mode_t;

    typedef struct packed {
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
    } rgb_t;

    typedef struct packed {
        logic [1:0] rsvd;
        logic [1:0] status_mux;
        logic [3:0] plane_en;
    } plane_reg_t;

    typedef struct packed {
        logic [3:0] rsvd;
        logic [3:0] code;
    } pan_reg_t;

    typedef struct packed {
        logic [3:0] rsvd;
        logic [1:0] high_pair;
        logic [1:0] low_pair;
    } colour_sel_reg_t;

    typedef enum logic [1:0] {
        SEQ_WRITE = 2'b01,
        SEQ_READ = 2'b10
    } seq_t;

endpackage

// file: rtl/attribute_and_palette_regs.sv
// Attribute tail registers, palette index and data ports, and the colour path to the converter.
`timescale 1ns/10ps
`include "attr_pal_cfg.svh"

// Notes on behaviour
// - Border colour writes are dropped while the attribute lock bit is set.
// - Outside the active area the whole border byte is the displayed colour.
// - A cleared plane enable bit forces that pixel bit to zero before lookup.
// - Status mux picks colour outputs 2/0, 5/4, 3/1 or 7 for status bits.
// - Nine-dot text shifts by code plus one for 0 to 7, none for 8.
// - Eight-dot text and ordinary graphics shift by the code, 0 to 7.
// - In 256-colour mode even codes 0,2,4,6 give pan positions 0 to 3.
// - Outside 256-colour mode the top two colour bits come from select bits 3:2.
// - When selected outside 256-colour mode, select bits 1:0 replace colour outputs 5 and 4.
// - In 256-colour pixel width the pixel clock runs at half rate.
// - With palette source cleared the video output is blanked.
// - Index then three data writes store red, green, blue in the table.
// - Each completed three-byte load advances the write index by one.
// - Index at the read port then three data reads return red, green, blue.
// - Read index port is written as index and read back as status.
// - Status reads 00 during a write sequence and 11 during a read sequence.
// - A cleared pixel mask bit drops that bit from the table lookup.
// - Writing the read index drives code 11 on the converter control.
// - Writing the write index drives code 11 on the converter control.
// - Any data port access drives code 01 on the converter control.
module attribute_and_palette_regs (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire attr_pal_pkg::io_req_t i_io,
    output logic [7:0] o_io_rdata,
    input wire attr_pal_pkg::mode_t i_mode,
    input wire logic [3:0] i_plane_pixel,
    output logic [3:0] o_plane_pixel,
    input wire logic [7:0] i_attr_colour,
    input wire logic i_display_active,
    output attr_pal_pkg::rgb_t o_rgb,
    output logic [3:0] o_pan_shift,
    output logic [1:0] o_status_pair,
    output logic o_pixel_clk_en,
    output logic [1:0] o_dac_ctrl
);
    import attr_pal_pkg::*;

    typedef struct packed {
        logic [7:0] border;
        plane_reg_t plane;
        pan_reg_t pan;
        colour_sel_reg_t colour_sel;
        logic [7:0] mask;
        logic [7:0] rd_index;
        logic [7:0] wr_index;
        seq_t seq;
        logic [1:0] byte_cnt;
        logic [7:0] red;
        logic [7:0] green;
        logic [1:0] dac_ctrl;
        logic [7:0] rdata;
        logic [3:0] plane_pixel;
        logic [3:0] pan_shift;
        logic [1:0] status_pair;
        logic clk_phase;
        rgb_t rgb;
    } state_t;

    state_t st;
    state_t next_st;

    logic attr_wr;
    logic data_wr;
    logic data_rd;
    logic lut_we;
    rgb_t lut_wdata;
    rgb_t host_rgb;
    rgb_t video_rgb;
    logic [7:0] colour_index;
    logic [7:0] video_index;

    // --------------------------------------------------------------------
    // Access decode
    // --------------------------------------------------------------------
    assign attr_wr = i_io.wr && (i_io.addr == `IO_ATTR_WRITE);
    assign data_wr = i_io.wr && (i_io.addr == `IO_PALETTE_DATA);
    assign data_rd = i_io.rd && !i_io.wr && (i_io.addr == `IO_PALETTE_DATA);
    assign lut_we = data_wr && (st.byte_cnt == `BYTE_LAST);
    assign lut_wdata = '{red: st.red, green: st.green, blue: i_io.wdata};

    // --------------------------------------------------------------------
    // Colour index formation
    // --------------------------------------------------------------------
    always_comb begin
        colour_index = i_attr_colour;
        if (!i_mode.mode256) begin
            colour_index[7:6] = st.colour_sel.high_pair;
            if (i_mode.vid_select) begin
                colour_index[5:4] = st.colour_sel.low_pair;
            end
        end
        if (!i_display_active) begin
            colour_index = st.border;
        end
        video_index = colour_index & st.mask;
    end

    palette_lut u_lut (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_we(lut_we),
        .i_waddr(st.wr_index),
        .i_wdata(lut_wdata),
        .i_host_addr(st.rd_index),
        .o_host_rgb(host_rgb),
        .i_video_addr(video_index),
        .o_video_rgb(video_rgb)
    );

    // --------------------------------------------------------------------
    // Next state
    // --------------------------------------------------------------------
    always_comb begin
        next_st = st;
        // Attribute registers behind the index/data port.
        if (attr_wr) begin
            case (i_io.attr_index)
                `IDX_BORDER: begin
                    if (!i_mode.lock) begin
                        next_st.border = i_io.wdata;
                    end
                end
                `IDX_PLANE: begin
                    next_st.plane = i_io.wdata;
                    next_st.plane.rsvd = '0;
                end
                `IDX_PAN: begin
                    next_st.pan = i_io.wdata;
                    next_st.pan.rsvd = '0;
                end
                `IDX_COLOUR_SEL: begin
                    next_st.colour_sel = i_io.wdata;
                    next_st.colour_sel.rsvd = '0;
                end
                default: begin
                end
            endcase
        end
        // Palette ports; a write takes precedence over a read in the same cycle.
        if (i_io.wr) begin
            case (i_io.addr)
                `IO_PIXEL_MASK: begin
                    next_st.mask = i_io.wdata;
                end
                `IO_READ_INDEX: begin
                    next_st.rd_index = i_io.wdata;
                    next_st.seq = SEQ_READ;
                    next_st.byte_cnt = `BYTE_FIRST;
                    next_st.dac_ctrl = `CTRL_INDEX;
                end
                `IO_WRITE_INDEX: begin
                    next_st.wr_index = i_io.wdata;
                    next_st.seq = SEQ_WRITE;
                    next_st.byte_cnt = `BYTE_FIRST;
                    next_st.dac_ctrl = `CTRL_INDEX;
                end
                `IO_PALETTE_DATA: begin
                    next_st.dac_ctrl = `CTRL_DATA;
                    case (st.byte_cnt)
                        `BYTE_FIRST: begin
                            next_st.red = i_io.wdata;
                            next_st.byte_cnt = `BYTE_SECOND;
                        end
                        `BYTE_SECOND: begin
                            next_st.green = i_io.wdata;
                            next_st.byte_cnt = `BYTE_LAST;
                        end
                        default: begin
                            next_st.wr_index = st.wr_index + `INDEX_STEP;
                            next_st.byte_cnt = `BYTE_FIRST;
                        end
                    endcase
                end
                default: begin
                end
            endcase
        end else if (data_rd) begin
            next_st.dac_ctrl = `CTRL_DATA;
            case (st.byte_cnt)
                `BYTE_FIRST: begin
                    next_st.byte_cnt = `BYTE_SECOND;
                end
                `BYTE_SECOND: begin
                    next_st.byte_cnt = `BYTE_LAST;
                end
                default: begin
                    next_st.rd_index = st.rd_index + `INDEX_STEP;
                    next_st.byte_cnt = `BYTE_FIRST;
                end
            endcase
        end
        // Read data, captured one cycle after the read strobe.
        next_st.rdata = `READ_ZERO;
        if (i_io.rd && !i_io.wr) begin
            case (i_io.addr)
                `IO_ATTR_READ: begin
                    case (i_io.attr_index)
                        `IDX_BORDER: next_st.rdata = st.border;
                        `IDX_PLANE: next_st.rdata = st.plane;
                        `IDX_PAN: next_st.rdata = st.pan;
                        `IDX_COLOUR_SEL: next_st.rdata = st.colour_sel;
                        default: next_st.rdata = `READ_ZERO;
                    endcase
                end
                `IO_PIXEL_MASK: next_st.rdata = st.mask;
                `IO_READ_INDEX: begin
                    case (st.seq)
                        SEQ_READ: next_st.rdata = {6'h00, `STATUS_READ};
                        SEQ_WRITE: next_st.rdata = {6'h00, `STATUS_WRITE};
                        default: next_st.rdata = `READ_ZERO;
                    endcase
                end
                `IO_WRITE_INDEX: next_st.rdata = st.wr_index;
                `IO_PALETTE_DATA: begin
                    case (st.byte_cnt)
                        `BYTE_FIRST: next_st.rdata = host_rgb.red;
                        `BYTE_SECOND: next_st.rdata = host_rgb.green;
                        default: next_st.rdata = host_rgb.blue;
                    endcase
                end
                default: next_st.rdata = `READ_ZERO;
            endcase
        end
        // Plane enables gate the memory plane bits.
        next_st.plane_pixel = i_plane_pixel & st.plane.plane_en;
        // Status pair from the current colour outputs.
        case (st.plane.status_mux)
            `MUX_PAIR_20: next_st.status_pair = {i_attr_colour[2], i_attr_colour[0]};
            `MUX_PAIR_54: next_st.status_pair = {i_attr_colour[5], i_attr_colour[4]};
            `MUX_PAIR_31: next_st.status_pair = {i_attr_colour[3], i_attr_colour[1]};
            default: next_st.status_pair = {1'b0, i_attr_colour[7]};
        endcase
        // Horizontal pan amount by mode.
        if (i_mode.mode256) begin
            next_st.pan_shift = {2'b00, st.pan.code[2:1]};
        end else if (i_mode.text && i_mode.nine_dot) begin
            if (st.pan.code <= `PAN_LINEAR_MAX) begin
                next_st.pan_shift = st.pan.code + `PAN_STEP;
            end else begin
                next_st.pan_shift = `PAN_NONE;
            end
        end else begin
            next_st.pan_shift = {1'b0, st.pan.code[2:0]};
        end
        // Half-rate pixel clock in 256-colour pixel width.
        next_st.clk_phase = i_mode.mode256 ? !st.clk_phase : 1'b1;
        next_st.rgb = i_mode.palette_source_enable ? video_rgb : '0;
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st <= '{border: `ATTR_RESET, plane: `ATTR_RESET, pan: `ATTR_RESET,
                    colour_sel: `ATTR_RESET, mask: `MASK_RESET, rd_index: `INDEX_RESET,
                    wr_index: `INDEX_RESET, seq: SEQ_WRITE, byte_cnt: `BYTE_FIRST,
                    red: `READ_ZERO, green: `READ_ZERO, dac_ctrl: `CTRL_IDLE,
                    rdata: `READ_ZERO, plane_pixel: 4'h0, pan_shift: `PAN_NONE,
                    status_pair: 2'b00, clk_phase: 1'b1, rgb: '0};
        end else begin
            st <= next_st;
        end
    end

    assign o_io_rdata = st.rdata;
    assign o_plane_pixel = st.plane_pixel;
    assign o_pan_shift = st.pan_shift;
    assign o_status_pair = st.status_pair;
    assign o_pixel_clk_en = st.clk_phase;
    assign o_rgb = st.rgb;
    assign o_dac_ctrl = st.dac_ctrl;

    // --------------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_b);

    sequence s_data_write;
        data_wr;
    endsequence

    sequence s_read_index_write;
        i_io.wr && (i_io.addr == `IO_READ_INDEX);
    endsequence

    a_border_locked: assert property (
        attr_wr && (i_io.attr_index == `IDX_BORDER) && i_mode.lock |=> $stable(st.border))
        else $error("border colour changed while locked");

    a_plane_forced: assert property (
        ##1 ((o_plane_pixel & ~$past(st.plane.plane_en)) == 4'h0))
        else $error("disabled plane bit reached the palette");

    a_pan_nine_zero: assert property (
        !i_mode.mode256 && i_mode.text && i_mode.nine_dot && st.pan.code == `PAN_NINE_ZERO
        |=> o_pan_shift == `PAN_NONE)
        else $error("nine-dot pan code 8 did not give zero shift");

    a_load_advance: assert property (
        s_data_write ##0 (st.byte_cnt == `BYTE_LAST)
        |=> st.wr_index == $past(st.wr_index) + `INDEX_STEP && st.byte_cnt == `BYTE_FIRST)
        else $error("write index did not advance after three data bytes");

    a_read_wrap: assert property (
        data_rd && st.byte_cnt == `BYTE_LAST
        |=> st.rd_index == $past(st.rd_index) + `INDEX_STEP && st.byte_cnt == `BYTE_FIRST)
        else $error("read index did not advance after third byte");

    a_read_status: assert property (
        s_read_index_write ##1 !i_io.wr ##1 (i_io.rd && !i_io.wr && i_io.addr == `IO_READ_INDEX)
        |=> o_io_rdata == {6'h00, `STATUS_READ})
        else $error("read sequence status code wrong");

    a_index_ctrl: assert property (
        i_io.wr && (i_io.addr == `IO_READ_INDEX || i_io.addr == `IO_WRITE_INDEX)
        |=> o_dac_ctrl == `CTRL_INDEX)
        else $error("index write did not drive code 11");

    a_read_index_load: assert property (
        s_read_index_write |=> st.rd_index == $past(i_io.wdata))
        else $error("read index not loaded from port write");

    a_data_ctrl: assert property (
        data_wr || data_rd |=> o_dac_ctrl == `CTRL_DATA)
        else $error("data access did not drive code 01");

    a_blank_source: assert property (
        !i_mode.palette_source_enable |=> o_rgb == '0)
        else $error("video not blanked with palette source cleared");

    a_half_clock: assert property (
        i_mode.mode256 ##1 i_mode.mode256 |-> o_pixel_clk_en != $past(o_pixel_clk_en))
        else $error("pixel clock enable not toggling in 256-colour width");

    a_status_pair: assert property (
        st.plane.status_mux == `MUX_PAIR_54 ##1 1'b1
        |-> o_status_pair == {$past(i_attr_colour[5]), $past(i_attr_colour[4])})
        else $error("status pair does not follow colour outputs 5 and 4");
endmodule

// file: rtl/palette_lut.sv
// Colour lookup table of 256 entries with a host port and a registered video port.
`timescale 1ns/10ps
module palette_lut (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_we,
    input wire logic [7:0] i_waddr,
    input wire attr_pal_pkg::rgb_t i_wdata,
    input wire logic [7:0] i_host_addr,
    output attr_pal_pkg::rgb_t o_host_rgb,
    input wire logic [7:0] i_video_addr,
    output attr_pal_pkg::rgb_t o_video_rgb
);
    import attr_pal_pkg::*;

    typedef struct packed {
        rgb_t [255:0] entry;
        rgb_t video;
    } lut_state_t;

    lut_state_t st;
    lut_state_t next_st;

    always_comb begin
        next_st = st;
        if (i_we) begin
            next_st.entry[i_waddr] = i_wdata;
        end
        next_st.video = st.entry[i_video_addr];
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_host_rgb = st.entry[i_host_addr];
    assign o_video_rgb = st.video;
endmodule

// file: tb/attribute_and_palette_regs_test.sv
// Self-checking testbench for the attribute and palette register block.
`timescale 1ns/10ps
`include "attr_pal_cfg.svh"
module attribute_and_palette_regs_test;
    import attr_pal_pkg::*;

    logic i_clk_sys;
    logic i_rst_b;
    io_req_t io;
    mode_t mode;
    logic [3:0] plane_pixel;
    logic [7:0] attr_colour;
    logic display_active;
    logic [7:0] o_io_rdata;
    logic [3:0] o_plane_pixel;
    rgb_t o_rgb;
    logic [3:0] o_pan_shift;
    logic [1:0] o_status_pair;
    logic o_pixel_clk_en;
    logic [1:0] o_dac_ctrl;
    int mismatches;
    int checks_done;
    logic [1:0] mux_exp [4] = '{2'b11, 2'b01, 2'b10, 2'b00};
    logic [23:0] entry_a = 24'h112233;
    logic [23:0] entry_b = 24'h445566;
    logic pclk_prev;

    attribute_and_palette_regs u_dut (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_io(io),
        .o_io_rdata(o_io_rdata),
        .i_mode(mode),
        .i_plane_pixel(plane_pixel),
        .o_plane_pixel(o_plane_pixel),
        .i_attr_colour(attr_colour),
        .i_display_active(display_active),
        .o_rgb(o_rgb),
        .o_pan_shift(o_pan_shift),
        .o_status_pair(o_status_pair),
        .o_pixel_clk_en(o_pixel_clk_en),
        .o_dac_ctrl(o_dac_ctrl)
    );

    initial begin
        i_clk_sys = 1'b0;
        forever #4 i_clk_sys = ~i_clk_sys;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic finish_test();
        $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic io_write(input logic [15:0] addr, input logic [4:0] idx, input logic [7:0] data);
        @(negedge i_clk_sys);
        io.addr = addr;
        io.attr_index = idx;
        io.wdata = data;
        io.wr = 1'b1;
        @(negedge i_clk_sys);
        io.wr = 1'b0;
    endtask

    task automatic read_check(input logic [15:0] addr, input logic [4:0] idx, input logic [7:0] exp);
        @(negedge i_clk_sys);
        io.addr = addr;
        io.attr_index = idx;
        io.rd = 1'b1;
        @(negedge i_clk_sys);
        io.rd = 1'b0;
        check({16'h0000, o_io_rdata}, {16'h0000, exp});
    endtask

    task automatic settle();
        repeat (3) @(negedge i_clk_sys);
    endtask

    task automatic video_check(input logic [7:0] colour, input logic active, input logic [23:0] exp);
        attr_colour = colour;
        display_active = active;
        settle();
        check(o_rgb, exp);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        io = '0;
        mode = '0;
        plane_pixel = 4'h0;
        attr_colour = 8'h00;
        display_active = 1'b1;
        mismatches = 0;
        checks_done = 0;
        i_rst_b = 1'b0;
        repeat (4) @(negedge i_clk_sys);
        i_rst_b = 1'b1;
        check({22'h0, o_dac_ctrl}, {22'h0, `CTRL_IDLE});
        check({23'h0, o_pixel_clk_en}, 24'h000001);
        for (int i = 0; i < 4; i++) begin
            read_check(`IO_ATTR_READ, 5'h11 + i[4:0], `ATTR_RESET);
        end
        read_check(`IO_PIXEL_MASK, 5'h00, `MASK_RESET);
        // Reserved bits read back as zero; unmapped index and port read zero.
        io_write(`IO_ATTR_WRITE, `IDX_BORDER, 8'hff);
        io_write(`IO_ATTR_WRITE, `IDX_PLANE, 8'hff);
        io_write(`IO_ATTR_WRITE, `IDX_PAN, 8'hff);
        io_write(`IO_ATTR_WRITE, `IDX_COLOUR_SEL, 8'hff);
        io_write(`IO_ATTR_WRITE, 5'h15, 8'hff);
        read_check(`IO_ATTR_READ, `IDX_BORDER, 8'hff);
        read_check(`IO_ATTR_READ, `IDX_PLANE, 8'h3f);
        read_check(`IO_ATTR_READ, `IDX_PAN, 8'h0f);
        read_check(`IO_ATTR_READ, `IDX_COLOUR_SEL, 8'h0f);
        read_check(`IO_ATTR_READ, 5'h15, 8'h00);
        read_check(16'h03c5, 5'h00, 8'h00);
        // Border writes are dropped while locked and taken once unlocked.
        mode.lock = 1'b1;
        io_write(`IO_ATTR_WRITE, `IDX_BORDER, 8'h5a);
        read_check(`IO_ATTR_READ, `IDX_BORDER, 8'hff);
        mode.lock = 1'b0;
        io_write(`IO_ATTR_WRITE, `IDX_BORDER, 8'h5a);
        read_check(`IO_ATTR_READ, `IDX_BORDER, 8'h5a);
        io_write(`IO_ATTR_WRITE, `IDX_BORDER, 8'hff);
        // Two consecutive palette loads from one index write, wrapping the index.
        io_write(`IO_WRITE_INDEX, 5'h00, 8'hfe);
        check({22'h0, o_dac_ctrl}, {22'h0, `CTRL_INDEX});
        for (int i = 0; i < 6; i++) begin
            io_write(`IO_PALETTE_DATA, 5'h00, (i < 3) ? entry_a[23 - 8 * i -: 8] : entry_b[47 - 8 * i -: 8]);
        end
        check({22'h0, o_dac_ctrl}, {22'h0, `CTRL_DATA});
        read_check(`IO_WRITE_INDEX, 5'h00, 8'h00);
        read_check(`IO_READ_INDEX, 5'h00, {6'h00, `STATUS_WRITE});
        // Read back both entries with one read index write.
        io_write(`IO_READ_INDEX, 5'h00, 8'hfe);
        check({22'h0, o_dac_ctrl}, {22'h0, `CTRL_INDEX});
        read_check(`IO_READ_INDEX, 5'h00, {6'h00, `STATUS_READ});
        for (int i = 0; i < 6; i++) begin
            read_check(`IO_PALETTE_DATA, 5'h00, (i < 3) ? entry_a[23 - 8 * i -: 8] : entry_b[47 - 8 * i -: 8]);
        end
        check({22'h0, o_dac_ctrl}, {22'h0, `CTRL_DATA});
        // ------------------------------------------------------------
        // Video colour path
        // ------------------------------------------------------------
        mode.palette_source_enable = 1'b1;
        mode.mode256 = 1'b1;
        video_check(8'hfe, 1'b1, entry_a);
        io_write(`IO_PIXEL_MASK, 5'h00, 8'hfe);
        video_check(8'hff, 1'b1, entry_a);
        io_write(`IO_PIXEL_MASK, 5'h00, 8'hff);
        video_check(8'hff, 1'b1, entry_b);
        mode.mode256 = 1'b0;
        io_write(`IO_ATTR_WRITE, `IDX_COLOUR_SEL, 8'h00);
        video_check(8'hfe, 1'b1, 24'h000000);
        video_check(8'h00, 1'b0, entry_b);
        io_write(`IO_ATTR_WRITE, `IDX_COLOUR_SEL, 8'h0c);
        video_check(8'h3e, 1'b1, entry_a);
        io_write(`IO_ATTR_WRITE, `IDX_COLOUR_SEL, 8'h0f);
        mode.vid_select = 1'b1;
        video_check(8'h0e, 1'b1, entry_a);
        video_check(8'h3f, 1'b1, entry_b);
        mode.vid_select = 1'b0;
        video_check(8'h0e, 1'b1, 24'h000000);
        mode.palette_source_enable = 1'b0;
        video_check(8'h3f, 1'b1, 24'h000000);
        // Status multiplexer and plane enables.
        plane_pixel = 4'hf;
        for (int m = 0; m < 4; m++) begin
            io_write(`IO_ATTR_WRITE, `IDX_PLANE, {2'b00, m[1:0], 4'h1 << m});
            attr_colour = 8'h1d;
            settle();
            check({22'h0, o_status_pair}, {22'h0, mux_exp[m]});
            check({20'h0, o_plane_pixel}, {20'h0, 4'h1 << m});
        end
        // ------------------------------------------------------------
        // Horizontal panning for nine-dot text codes 0 to 8, eight-dot text codes 0 to 7 and 256-colour even codes 0 to 6
        // ------------------------------------------------------------
        mode.text = 1'b1;
        mode.nine_dot = 1'b1;
        for (int c = 0; c < 9; c++) begin
            io_write(`IO_ATTR_WRITE, `IDX_PAN, c[7:0]);
            settle();
            check({20'h0, o_pan_shift}, 24'((c < 8) ? c + 1 : 0));
        end
        mode.nine_dot = 1'b0;
        for (int c = 0; c < 8; c++) begin
            io_write(`IO_ATTR_WRITE, `IDX_PAN, c[7:0]);
            settle();
            check({20'h0, o_pan_shift}, 24'(c));
        end
        mode.text = 1'b0;
        mode.mode256 = 1'b1;
        for (int c = 0; c < 4; c++) begin
            io_write(`IO_ATTR_WRITE, `IDX_PAN, 8'(2 * c));
            settle();
            check({20'h0, o_pan_shift}, 24'(c));
        end
        // Pixel clock enable toggles at half rate in 256-colour width.
        pclk_prev = o_pixel_clk_en;
        @(negedge i_clk_sys);
        check({23'h0, o_pixel_clk_en}, {23'h0, ~pclk_prev});
        mode.mode256 = 1'b0;
        settle();
        check({23'h0, o_pixel_clk_en}, 24'h000001);
        finish_test();
    end

    initial begin
        #200000;
        mismatches++;
        finish_test();
    end
endmodule
